// [shared/cps_pkg.sv]
// constants, register map and types for the clock pin function select block
`default_nettype none
package cps_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned FS_BITS = 3;
  localparam int unsigned NUM_PAIRS = 4;
  localparam int unsigned NUM_SYNC = 8;

  // register indices: byte address is four times the index
  localparam logic [5:0] REG_IDX_OUT_EN = 6'h03;
  localparam logic [5:0] REG_IDX_PIN_FUNC = 6'h06;
  localparam logic [5:0] REG_IDX_CTRL = 6'h08;
  localparam logic [5:0] REG_IDX_STATUS = 6'h09;

  // output enable byte
  localparam int unsigned OE_SIX_BIT = 2;
  localparam int unsigned OE_SEVEN_BIT = 3;
  localparam int unsigned OE_EIGHT_BIT = 4;
  // pin function byte
  localparam int unsigned FUNC_F_BIT = 6;
  localparam int unsigned FUNC_E_BIT = 7;
  // control byte
  localparam int unsigned CTRL_FSA_BIT = 0;
  localparam int unsigned CTRL_FSC_BIT = 2;
  localparam int unsigned CTRL_MGMT_ARM_BIT = 4;
  localparam int unsigned CTRL_TEST_BIT = 5;
  // status word
  localparam int unsigned ST_STRAP_DONE_BIT = 0;
  localparam int unsigned ST_DEBUG_SEL_BIT = 1;
  localparam int unsigned ST_MGMT_BIT = 2;
  localparam int unsigned ST_PDN_BIT = 3;
  localparam int unsigned ST_FS_LSB = 4;
  localparam int unsigned ST_FUNC_E_BIT = 7;
  localparam int unsigned ST_FUNC_F_BIT = 8;

  localparam logic [7:0] OUT_EN_RST = 8'hff;
  localparam logic [7:0] PIN_FUNC_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // pair indices
  localparam int unsigned P_SIX = 0;
  localparam int unsigned P_SEVEN = 1;
  localparam int unsigned P_EIGHT = 2;
  localparam int unsigned P_CPU1 = 3;

  // synchroniser lanes
  localparam int unsigned S_PWRGD = 0;
  localparam int unsigned S_STRAP = 1;
  localparam int unsigned S_FSB = 2;
  localparam int unsigned S_SH_DATA = 3;
  localparam int unsigned S_SH_CLK = 4;
  localparam int unsigned S_STOP = 5;
  localparam int unsigned S_REQ_E = 6;
  localparam int unsigned S_REQ_F = 7;

  typedef enum logic [1:0] {PWR_WAIT_GOOD, PWR_RUN, PWR_DOWN, PWR_MGMT} cps_pwr_t;
endpackage
`default_nettype wire

// [rtl/cps_sync.sv]
// two-flop synchroniser bank for pin inputs
`default_nettype none
module cps_sync #(
  parameter int unsigned W = 1
) (
  input wire logic CLK, // system clock
  input wire logic RST_B, // async reset, active low
  input wire logic [W-1:0] d, // asynchronous pin levels
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  initial begin
    if (W < 1) $error("cps_sync: W must be at least 1");
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule
`default_nettype wire

// [rtl/cps_fs_shift.sv]
// serial frequency-select loader used in management mode
`default_nettype none
module cps_fs_shift #(
  parameter int unsigned NBITS = 3
) (
  input wire logic CLK, // system clock
  input wire logic RST_B, // async reset, active low
  input wire logic en, // management mode active
  input wire logic bit_stb, // one-cycle pulse per rising shift clock
  input wire logic bit_in, // synchronised serial data
  output logic load, // one-cycle pulse, word complete
  output logic [NBITS-1:0] word // assembled word, first bit is msb
);
  logic [NBITS-1:0] sh_r;
  logic [$clog2(NBITS+1)-1:0] cnt_r;
  logic load_r;

  initial begin
    if (NBITS < 2) $error("cps_fs_shift: NBITS must be at least 2");
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sh_r <= '0;
      cnt_r <= '0;
      load_r <= 1'b0;
    end else begin
      load_r <= 1'b0;
      if (!en) begin
        cnt_r <= '0;
      end else if (bit_stb) begin
        sh_r <= {sh_r[NBITS-2:0], bit_in};
        if (cnt_r == ($clog2(NBITS+1))'(NBITS - 1)) begin
          cnt_r <= '0;
          load_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

  assign load = load_r;
  assign word = sh_r;
endmodule
`default_nettype wire

// [rtl/cps_pin_select.sv]
// pin function select, strap latch and power state for the shared clock pins
`default_nettype none
// What this block does
// R01 - complement pin of pair seven drives clock; byte6 bit7 makes it request E for six
// R02 - host disables pair seven (byte3 bit3) before turning its pins into requests
// R03 - true pin of pair seven drives clock; byte6 bit6 makes it request F for eight
// R04 - a pair disabled by configuration puts both pins in high impedance; the debug clock on pair eight pins stays driven
// R05 - strap latched at power-up: 0 gives pair eight, 1 the debug clock
// R06 - cpu pair one runs free, ignoring stop, in management mode
// R07 - power-good edges latch straps, enter/leave management or power-down
// R08 - in test mode the test-select level picks high-z or divided reference live
// R09 - frequency-select b input is one of the cpu frequency selection bits
// R10 - in management mode three select bits shift in on a separate clock pin
// R11 - request-controlled pair runs while active-low request is low, stops otherwise
// R12 - pin function switches to request only once the owning pair is disabled
module cps_pin_select
  import cps_pkg::*;
(
  input wire logic CLK, // system clock, 20 MHz
  input wire logic RST_B, // async reset, active low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb write
  input wire logic [cps_pkg::ADDR_W-1:0] PADDR, // apb byte address
  input wire logic [cps_pkg::DATA_W-1:0] PWDATA, // apb write data
  output logic [cps_pkg::DATA_W-1:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error, unmapped address
  input wire logic POWER_GOOD_POWERDOWN_IN, // power good / power down pin
  input wire logic DEBUG_CLOCK_STRAP, // strap choosing debug clock on pair eight pins
  input wire logic FREQ_SELECT_B, // frequency select b, test select in test mode
  input wire logic FS_SHIFT_DATA, // serial select data in management mode
  input wire logic FS_SHIFT_CLK, // serial select bit clock in management mode
  input wire logic CPU_STOP_B, // stop request for cpu clocks, active low
  input wire logic SRC_CLK_IN, // reference clock level from the synthesiser
  input wire logic CPU_CLK_IN, // cpu clock level from the synthesiser
  input wire logic DEBUG_CLK_IN, // debug-port cpu clock level
  input wire logic REF_DIV_N_IN, // reference divided by n, test mode source
  output logic REF_PAIR_SIX_T_O, // pair six true
  output logic REF_PAIR_SIX_C_O, // pair six complement
  output logic REF_PAIR_SIX_OE, // pair six drive enable
  input wire logic SEVEN_T_I, // pair seven true pin level (clkreq_in_f)
  output logic SEVEN_T_O, // pair seven true drive value
  output logic SEVEN_T_OE, // pair seven true drive enable
  input wire logic SEVEN_C_I, // pair seven complement pin level (clkreq_in_e)
  output logic SEVEN_C_O, // pair seven complement drive value
  output logic SEVEN_C_OE, // pair seven complement drive enable
  output logic EIGHT_T_O, // pair eight or debug clock true
  output logic EIGHT_C_O, // pair eight or debug clock complement
  output logic EIGHT_OE, // pair eight pins drive enable
  output logic CPU_PAIR_ONE_FREERUN_T_O, // cpu pair one true
  output logic CPU_PAIR_ONE_FREERUN_C_O, // cpu pair one complement
  output logic CPU_PAIR_ONE_FREERUN_OE, // cpu pair one drive enable
  output logic [cps_pkg::FS_BITS-1:0] FREQ_SEL, // cpu frequency selection
  output logic MGMT_MODE, // management mode active
  output logic POWER_DOWN // power-down mode active
);
  import cps_pkg::*;

  logic [NUM_SYNC-1:0] pin_raw;
  logic [NUM_SYNC-1:0] pin_s;
  logic pg_d_r, sh_clk_d_r;
  logic pg_rise, pg_fall, sh_stb;
  logic fs_load;
  logic [FS_BITS-1:0] fs_word;
  cps_pwr_t state_r, state_nxt;
  logic [7:0] out_en_r, pin_func_r, ctrl_r;
  logic func_e_r, func_f_r;
  logic strap_done_r, debug_sel_r;
  logic [FS_BITS-1:0] fs_r;
  logic mgmt_r, pdn_r;
  logic pready_r, pslverr_r;
  logic [DATA_W-1:0] prdata_r, rd_data, status;
  logic rd_hit, acc, wr_en;
  logic running, test_act, test_sel;
  logic [NUM_PAIRS-1:0] pr_run, pr_oe_t, pr_oe_c, pr_clk;
  logic [NUM_PAIRS-1:0] t_r, c_r, oe_t_r, oe_c_r;

  assign pin_raw = {SEVEN_T_I, SEVEN_C_I, CPU_STOP_B, FS_SHIFT_CLK, FS_SHIFT_DATA,
                    FREQ_SELECT_B, DEBUG_CLOCK_STRAP, POWER_GOOD_POWERDOWN_IN};

  cps_sync #(.W(NUM_SYNC)) u_sync (
    .CLK(CLK),
    .RST_B(RST_B),
    .d(pin_raw),
    .q(pin_s)
  );

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pg_d_r <= 1'b0;
      sh_clk_d_r <= 1'b0;
    end else begin
      pg_d_r <= pin_s[S_PWRGD];
      sh_clk_d_r <= pin_s[S_SH_CLK];
    end
  end

  assign pg_rise = pin_s[S_PWRGD] & ~pg_d_r;
  assign pg_fall = ~pin_s[S_PWRGD] & pg_d_r;
  assign sh_stb = pin_s[S_SH_CLK] & ~sh_clk_d_r;

  cps_fs_shift #(.NBITS(FS_BITS)) u_fs_shift (
    .CLK(CLK),
    .RST_B(RST_B),
    .en(state_r == PWR_MGMT), // R10
    .bit_stb(sh_stb),
    .bit_in(pin_s[S_SH_DATA]),
    .load(fs_load),
    .word(fs_word)
  );

  // power state, driven by power-good edges
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PWR_WAIT_GOOD: if (pg_rise) state_nxt = PWR_RUN; // R07
      PWR_RUN: begin
        if (pg_fall) begin
          state_nxt = ctrl_r[CTRL_MGMT_ARM_BIT] ? PWR_MGMT : PWR_DOWN; // R07
        end
      end
      PWR_DOWN: if (pg_rise) state_nxt = PWR_RUN; // R07
      PWR_MGMT: if (pg_rise) state_nxt = PWR_RUN; // R07
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= PWR_WAIT_GOOD;
      mgmt_r <= 1'b0;
      pdn_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mgmt_r <= (state_nxt == PWR_MGMT);
      pdn_r <= (state_nxt == PWR_DOWN);
    end
  end

  // straps caught once, on the first power-good rise after reset
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      strap_done_r <= 1'b0;
      debug_sel_r <= 1'b0;
    end else if (state_r == PWR_WAIT_GOOD && pg_rise) begin
      strap_done_r <= 1'b1; // R07
      debug_sel_r <= pin_s[S_STRAP]; // R05
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      fs_r <= '0;
    end else if (state_r == PWR_WAIT_GOOD && pg_rise) begin
      fs_r <= {ctrl_r[CTRL_FSC_BIT], pin_s[S_FSB], ctrl_r[CTRL_FSA_BIT]}; // R09
    end else if (fs_load) begin
      fs_r <= fs_word; // R10
    end
  end

  // apb slave: one wait state, answer registered
  assign acc = PSEL & PENABLE & ~pready_r;
  assign wr_en = PSEL & PENABLE & pready_r & PWRITE & ~pslverr_r;

  always_comb begin
    status = '0;
    status[ST_STRAP_DONE_BIT] = strap_done_r;
    status[ST_DEBUG_SEL_BIT] = debug_sel_r;
    status[ST_MGMT_BIT] = mgmt_r;
    status[ST_PDN_BIT] = pdn_r;
    status[ST_FS_LSB +: FS_BITS] = fs_r;
    status[ST_FUNC_E_BIT] = func_e_r;
    status[ST_FUNC_F_BIT] = func_f_r;
    rd_hit = 1'b1;
    rd_data = '0;
    unique case (PADDR[ADDR_W-1:2])
      REG_IDX_OUT_EN: rd_data[7:0] = out_en_r;
      REG_IDX_PIN_FUNC: rd_data[7:0] = pin_func_r;
      REG_IDX_CTRL: rd_data[7:0] = ctrl_r;
      REG_IDX_STATUS: rd_data = status;
      default: rd_hit = 1'b0;
    endcase
    if (PADDR[1:0] != 2'h0) begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= acc;
      pslverr_r <= acc & ~rd_hit;
      if (acc) begin
        prdata_r <= (rd_hit && !PWRITE) ? rd_data : '0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      out_en_r <= OUT_EN_RST;
      pin_func_r <= PIN_FUNC_RST; // R01 R03
      ctrl_r <= CTRL_RST;
    end else if (wr_en) begin
      unique case (PADDR[ADDR_W-1:2])
        REG_IDX_OUT_EN: out_en_r <= PWDATA[7:0];
        REG_IDX_PIN_FUNC: pin_func_r <= PWDATA[7:0];
        REG_IDX_CTRL: ctrl_r <= PWDATA[7:0];
        default: ;
      endcase
    end
  end

  // a pin becomes a request input only while pair seven is disabled
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      func_e_r <= 1'b0;
      func_f_r <= 1'b0;
    end else begin
      if (!pin_func_r[FUNC_E_BIT]) begin
        func_e_r <= 1'b0;
      end else if (!out_en_r[OE_SEVEN_BIT]) begin
        func_e_r <= 1'b1; // R12 R02 R01
      end
      if (!pin_func_r[FUNC_F_BIT]) begin
        func_f_r <= 1'b0;
      end else if (!out_en_r[OE_SEVEN_BIT]) begin
        func_f_r <= 1'b1; // R12 R02 R03
      end
    end
  end

  assign running = (state_r == PWR_RUN) || (state_r == PWR_MGMT);
  assign test_act = ctrl_r[CTRL_TEST_BIT];
  assign test_sel = pin_s[S_FSB]; // R08

  // per-pair run, enable and source selection
  always_comb begin
    pr_run[P_SIX] = running & (~func_e_r | ~pin_s[S_REQ_E]); // R11
    pr_oe_t[P_SIX] = out_en_r[OE_SIX_BIT]; // R04
    pr_oe_c[P_SIX] = out_en_r[OE_SIX_BIT]; // R04
    pr_clk[P_SIX] = SRC_CLK_IN;

    pr_run[P_SEVEN] = running;
    pr_oe_t[P_SEVEN] = out_en_r[OE_SEVEN_BIT] & ~func_f_r; // R03 R04 R12
    pr_oe_c[P_SEVEN] = out_en_r[OE_SEVEN_BIT] & ~func_e_r; // R01 R04 R12
    pr_clk[P_SEVEN] = SRC_CLK_IN;

    if (debug_sel_r) begin
      pr_run[P_EIGHT] = running; // R05
      pr_oe_t[P_EIGHT] = 1'b1;
      pr_oe_c[P_EIGHT] = 1'b1;
      pr_clk[P_EIGHT] = DEBUG_CLK_IN; // R05
    end else begin
      pr_run[P_EIGHT] = running & (~func_f_r | ~pin_s[S_REQ_F]); // R11
      pr_oe_t[P_EIGHT] = out_en_r[OE_EIGHT_BIT]; // R04
      pr_oe_c[P_EIGHT] = out_en_r[OE_EIGHT_BIT]; // R04
      pr_clk[P_EIGHT] = SRC_CLK_IN; // R05
    end

    pr_run[P_CPU1] = (state_r == PWR_MGMT) | (running & pin_s[S_STOP]); // R06
    pr_oe_t[P_CPU1] = 1'b1;
    pr_oe_c[P_CPU1] = 1'b1;
    pr_clk[P_CPU1] = CPU_CLK_IN;
  end

  // output flops; a stopped pair parks true low, complement high
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
        t_r[p] <= 1'b0;
        c_r[p] <= 1'b0;
        oe_t_r[p] <= 1'b0;
        oe_c_r[p] <= 1'b0;
      end else if (test_act) begin
        t_r[p] <= REF_DIV_N_IN; // R08
        c_r[p] <= ~REF_DIV_N_IN;
        oe_t_r[p] <= pr_oe_t[p] & test_sel; // R08
        oe_c_r[p] <= pr_oe_c[p] & test_sel; // R08
      end else begin
        t_r[p] <= pr_run[p] & pr_clk[p];
        c_r[p] <= ~(pr_run[p] & pr_clk[p]);
        oe_t_r[p] <= pr_oe_t[p];
        oe_c_r[p] <= pr_oe_c[p];
      end
    end
  end

  assign REF_PAIR_SIX_T_O = t_r[P_SIX];
  assign REF_PAIR_SIX_C_O = c_r[P_SIX];
  assign REF_PAIR_SIX_OE = oe_t_r[P_SIX];
  assign SEVEN_T_O = t_r[P_SEVEN];
  assign SEVEN_T_OE = oe_t_r[P_SEVEN];
  assign SEVEN_C_O = c_r[P_SEVEN];
  assign SEVEN_C_OE = oe_c_r[P_SEVEN];
  assign EIGHT_T_O = t_r[P_EIGHT];
  assign EIGHT_C_O = c_r[P_EIGHT];
  assign EIGHT_OE = oe_t_r[P_EIGHT];
  assign CPU_PAIR_ONE_FREERUN_T_O = t_r[P_CPU1];
  assign CPU_PAIR_ONE_FREERUN_C_O = c_r[P_CPU1];
  assign CPU_PAIR_ONE_FREERUN_OE = oe_t_r[P_CPU1];
  assign FREQ_SEL = fs_r;
  assign MGMT_MODE = mgmt_r;
  assign POWER_DOWN = pdn_r;
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
endmodule
`default_nettype wire

// [tb/cps_far_model.sv]
// far-side model: request sources, serial select host, clock levels
`default_nettype none
module cps_far_model (
  input wire logic CLK, // clock
  input wire logic SEVEN_T_O, // true pin drive value
  input wire logic SEVEN_T_OE, // true pin drive enable
  input wire logic SEVEN_C_O, // complement pin drive value
  input wire logic SEVEN_C_OE, // complement pin drive enable
  output wire logic SEVEN_T_I, // true pin level
  output wire logic SEVEN_C_I, // complement pin level
  output var logic FS_SHIFT_CLK, // select bit clock
  output var logic FS_SHIFT_DATA, // select data
  output wire logic SRC_CLK_IN, // reference level
  output wire logic CPU_CLK_IN, // cpu level
  output wire logic DEBUG_CLK_IN, // debug level
  output wire logic REF_DIV_N_IN // divided reference level
);
  logic req_e_b = 1'b1;
  logic req_f_b = 1'b1;
  logic [1:0] div = 2'h0;
  // request sources drive only once the design lets go of the pin
  assign SEVEN_T_I = SEVEN_T_OE ? SEVEN_T_O : req_f_b;
  assign SEVEN_C_I = SEVEN_C_OE ? SEVEN_C_O : req_e_b;
  assign SRC_CLK_IN = div[0];
  assign CPU_CLK_IN = div[0];
  assign DEBUG_CLK_IN = div[1];
  assign REF_DIV_N_IN = ~div[1];
  always @(posedge CLK) begin
    div <= div + 2'h1;
  end
  initial begin
    FS_SHIFT_CLK = 1'b0;
    FS_SHIFT_DATA = 1'b0;
  end
  // msb first; shift clock idles low between frames
  task automatic shift(input logic [2:0] v);
    for (int i = 2; i >= 0; i--) begin
      @(posedge CLK);
      FS_SHIFT_DATA <= v[i];
      repeat (4) @(posedge CLK);
      FS_SHIFT_CLK <= 1'b1;
      repeat (4) @(posedge CLK);
      FS_SHIFT_CLK <= 1'b0;
    end
    @(posedge CLK);
    FS_SHIFT_DATA <= ~v[0];
  endtask
endmodule
`default_nettype wire

// [tb/cps_pin_select_properties.sv]
// port assertions for the pin function select block
`default_nettype none
module cps_pin_select_chk (
  input wire logic CLK, // clock
  input wire logic RST_B, // reset, active low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access
  input wire logic PREADY, // apb ready
  input wire logic PSLVERR, // apb error
  input wire logic POWER_GOOD_POWERDOWN_IN, // power good pin
  input wire logic CPU_CLK_IN, // cpu level
  input wire logic CPU_PAIR_ONE_FREERUN_T_O, // cpu pair true
  input wire logic CPU_PAIR_ONE_FREERUN_C_O, // cpu pair complement
  input wire logic REF_PAIR_SIX_T_O, // pair six true
  input wire logic REF_PAIR_SIX_C_O, // pair six complement
  input wire logic MGMT_MODE, // management mode
  input wire logic POWER_DOWN // power-down mode
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_apb_wait;
    PSEL && PENABLE && !PREADY |=> PREADY;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("ready not after one wait");
  property p_apb_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_apb_pulse: assert property (p_apb_pulse)
    else $error("ready longer than one cycle");
  property p_apb_err;
    PSLVERR |-> PREADY && PSEL && PENABLE;
  endproperty
  a_apb_err: assert property (p_apb_err)
    else $error("error outside ready");
  property p_mode_excl;
    !(MGMT_MODE && POWER_DOWN);
  endproperty
  a_mode_excl: assert property (p_mode_excl)
    else $error("both modes active");
  property p_mgmt_entry;
    $rose(MGMT_MODE) |-> !POWER_GOOD_POWERDOWN_IN && !$past(POWER_GOOD_POWERDOWN_IN, 2);
  endproperty
  a_mgmt_entry: assert property (p_mgmt_entry)
    else $error("management without power good low");
  property p_pdn_entry;
    $rose(POWER_DOWN) |-> !POWER_GOOD_POWERDOWN_IN;
  endproperty
  a_pdn_entry: assert property (p_pdn_entry)
    else $error("power-down without power good low");
  property p_cpu_free;
    MGMT_MODE && $past(MGMT_MODE, 2) |->
      CPU_PAIR_ONE_FREERUN_T_O == $past(CPU_CLK_IN) &&
      CPU_PAIR_ONE_FREERUN_C_O == !$past(CPU_CLK_IN);
  endproperty
  a_cpu_free: assert property (p_cpu_free)
    else $error("cpu pair one not running");
  property p_pdn_stop;
    POWER_DOWN && $past(POWER_DOWN, 2) |->
      !REF_PAIR_SIX_T_O && REF_PAIR_SIX_C_O && !CPU_PAIR_ONE_FREERUN_T_O;
  endproperty
  a_pdn_stop: assert property (p_pdn_stop)
    else $error("pairs run in power-down");
endmodule
bind cps_pin_select cps_pin_select_chk u_chk (.*);
`default_nettype wire

// [tb/tb_clock_pin_function_select.sv]
// self-checking bench for the clock pin function select block
`default_nettype none
module tb_clock_pin_function_select;
  timeunit 1ns;
  timeprecision 1ns;
  import cps_pkg::*;
  logic CLK = 1'b0;
  logic RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic POWER_GOOD_POWERDOWN_IN, DEBUG_CLOCK_STRAP, FREQ_SELECT_B, CPU_STOP_B;
  logic FS_SHIFT_DATA, FS_SHIFT_CLK, SRC_CLK_IN, CPU_CLK_IN, DEBUG_CLK_IN, REF_DIV_N_IN;
  logic SEVEN_T_I, SEVEN_T_O, SEVEN_T_OE, SEVEN_C_I, SEVEN_C_O, SEVEN_C_OE, er;
  logic REF_PAIR_SIX_T_O, REF_PAIR_SIX_C_O, REF_PAIR_SIX_OE, EIGHT_T_O, EIGHT_C_O, EIGHT_OE;
  logic CPU_PAIR_ONE_FREERUN_T_O, CPU_PAIR_ONE_FREERUN_C_O, CPU_PAIR_ONE_FREERUN_OE;
  logic MGMT_MODE, POWER_DOWN;
  logic [2:0] FREQ_SEL;
  int num_errors = 0;
  int comparisons = 0;
  always #25 CLK = ~CLK;
  cps_pin_select u_dut (.*);
  cps_far_model u_far (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 20) num_errors++;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(32'(er), 32'(e));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    w(6);
  endtask
  // s: 0 pair six, 1 pair eight, 2 cpu pair one, 3 pair seven; running means T seen high
  task automatic run_chk(input int s, input logic exp);
    logic [31:0] h;
    h = 32'h0;
    repeat (16) begin
      @(posedge CLK);
      h += s == 0 ? REF_PAIR_SIX_T_O : s == 1 ? EIGHT_T_O :
           s == 2 ? CPU_PAIR_ONE_FREERUN_T_O : SEVEN_T_O;
    end
    chk(32'(h != 0), 32'(exp));
  endtask
  task automatic pg(input logic v);
    POWER_GOOD_POWERDOWN_IN <= v;
    w(6);
  endtask
  task automatic conclude;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge CLK);
    num_errors++;
    conclude();
  end
  initial begin
    RST_B = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    POWER_GOOD_POWERDOWN_IN = 1'b0;
    DEBUG_CLOCK_STRAP = 1'b0;
    FREQ_SELECT_B = 1'b0;
    CPU_STOP_B = 1'b1;
    for (int s = 1; s >= 0; s--) begin
      POWER_GOOD_POWERDOWN_IN <= 1'b0;
      RST_B <= 1'b0;
      w(8);
      RST_B <= 1'b1;
      DEBUG_CLOCK_STRAP <= s[0];
      FREQ_SELECT_B <= ~s[0];
      rdc(8'h0c, 32'hff, 1'b0);
      rdc(8'h18, 32'h0, 1'b0);
      rdc(8'h3c, 32'h0, 1'b1);
      rdc(8'h0d, 32'h0, 1'b1);
      wr(8'h20, 32'h15);
      pg(1'b1);
      rdc(8'h24, 32'h51 | (s << 1) | ((1 - s) << 5), 1'b0);
      chk(32'(FREQ_SEL), {29'h0, 1'b1, ~s[0], 1'b1});
      chk(32'({SEVEN_T_OE, SEVEN_C_OE, EIGHT_OE, CPU_PAIR_ONE_FREERUN_OE}), 32'hf);
      run_chk(3, 1'b1);
      wr(8'h0c, 32'hef);
      chk(32'(EIGHT_OE), 32'(s));
      $display("test strap %0d done", s);
    end
    wr(8'h0c, 32'hfb);
    chk(32'(REF_PAIR_SIX_OE), 32'h0);
    wr(8'h18, 32'hc0);
    chk(32'({SEVEN_T_OE, SEVEN_C_OE}), 32'h3);
    wr(8'h0c, 32'hf7);
    chk(32'({SEVEN_T_OE, SEVEN_C_OE}), 32'h0);
    rdc(8'h24, 32'h1f1, 1'b0);
    run_chk(0, 1'b0);
    run_chk(1, 1'b0);
    u_far.req_e_b <= 1'b0;
    u_far.req_f_b <= 1'b0;
    w(6);
    run_chk(0, 1'b1);
    run_chk(1, 1'b1);
    $display("test pin function done");
    for (int b = 0; b < 2; b++) begin
      FREQ_SELECT_B <= b[0];
      wr(8'h20, 32'h35);
      chk(32'(REF_PAIR_SIX_OE), 32'(b));
    end
    wr(8'h20, 32'h15);
    $display("test mode done");
    CPU_STOP_B <= 1'b0;
    w(6);
    run_chk(2, 1'b0);
    pg(1'b0);
    chk(32'({MGMT_MODE, POWER_DOWN}), 32'h2);
    run_chk(2, 1'b1);
    u_far.shift(3'b010);
    w(6);
    chk(32'(FREQ_SEL), 32'h2);
    pg(1'b1);
    chk(32'({MGMT_MODE, POWER_DOWN}), 32'h0);
    wr(8'h20, 32'h05);
    pg(1'b0);
    chk(32'({MGMT_MODE, POWER_DOWN}), 32'h1);
    run_chk(0, 1'b0);
    pg(1'b1);
    run_chk(0, 1'b1);
    $display("test power modes done");
    conclude();
  end
endmodule
`default_nettype wire
